// File: hw/period_timer_pkg.sv
// package: register map, field layout and types for the period timer
package period_timer_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_COUNT = 8'h11;
  localparam logic [7:0] IDX_CTRL = 8'h12;
  localparam logic [7:0] IDX_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_PERIOD = 8'h92;
  localparam logic [9:0] ADDR_FLAGS = {IDX_FLAGS, 2'h0};
  localparam logic [9:0] ADDR_COUNT = {IDX_COUNT, 2'h0};
  localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'h0};
  localparam logic [9:0] ADDR_ENABLES = {IDX_ENABLES, 2'h0};
  localparam logic [9:0] ADDR_PERIOD = {IDX_PERIOD, 2'h0};
  // reset values
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // field positions
  localparam int MATCH_BIT = 1;
  localparam int RUN_BIT = 2;
  // prescale field codes
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  // prescaler terminal counts
  localparam logic [3:0] PRE_LAST1 = 4'h0;
  localparam logic [3:0] PRE_LAST4 = 4'h3;
  localparam logic [3:0] PRE_LAST16 = 4'hF;
  // instruction clock: one tick every four bus clocks
  localparam logic [1:0] INSN_LAST = 2'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // control register layout
  typedef struct packed {
    logic [3:0] post_divide_select;
    logic timer_run;
    logic [1:0] pre_divide_select;
  } timer_control_t;
  // time base handed to the pwm units
  typedef struct packed {
    logic [7:0] count;
    logic match;
  } pwm_base_t;
endpackage

// File: hw/period_timer_with_scalers.sv
// period timer with prescaler, period match, postscaler and axi4-lite registers
// Overview of operation
// - 8-bit count register, read/write, reset zero
// - count from instruction clock through selectable prescaler
// - count to period, then wrap to zero
// - 8-bit period register, reset all ones
// - postscaler divides match, sets flag bit 1
// - run bit clear stops the timer
// - count or control write zeroes both scalers
// - control write leaves count unchanged
// - pre-postscaler match pulse to serial port
// - count and match exported as pwm base
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module period_timer_with_scalers
  import period_timer_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt and exported timing
  output logic irq,
  output logic sync_serial_port_tick,
  output pwm_base_t capture_compare_pwm_unit_base
);

  // prescaler terminal count per field code
  function automatic logic [3:0] pre_last(input logic [1:0] sel);
    case (sel)
      PRE_DIV1: pre_last = PRE_LAST1;
      PRE_DIV4: pre_last = PRE_LAST4;
      default: pre_last = PRE_LAST16;
    endcase
  endfunction

  // word address match helper
  function automatic logic hit(input logic [11:0] a, input logic [9:0] reg_addr);
    hit = (a[11:2] == {2'h0, reg_addr[9:2]});
  endfunction

  // timer state
  logic [7:0] count_r, count_nxt; // tick_count
  logic [7:0] period_r, period_nxt; // period_match_value
  timer_control_t ctrl_r, ctrl_nxt; // timer_control
  logic [1:0] insn_r, insn_nxt; // fosc/4 divider
  logic [3:0] pre_r, pre_nxt; // prescaler counter
  logic [3:0] post_r, post_nxt; // postscaler counter
  logic match_flag_r, match_flag_nxt; // match_event_flag
  logic match_en_r, match_en_nxt; // match_event_enable
  logic [7:0] other_flags_r, other_flags_nxt; // remaining flag bits, plain storage
  logic [7:0] other_en_r, other_en_nxt; // remaining enable bits
  logic match_pulse_r, match_pulse_nxt; // registered match pulse

  // bus state
  logic [11:0] aw_r, aw_nxt;
  logic aw_full_r, aw_full_nxt;
  logic [31:0] w_r, w_nxt;
  logic [3:0] ws_r, ws_nxt;
  logic w_full_r, w_full_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  // write strobes decoded from the buffered write
  logic do_wr;
  logic wr_lane0;
  logic wr_count, wr_ctrl, wr_period, wr_flags, wr_en;
  logic wr_mapped;
  logic insn_tick, pre_tick, match_now;
  logic [7:0] rd_word;
  logic rd_mapped;

  // handshakes are combinational from the holding state
  assign s_axi_awready = !aw_full_r;
  assign s_axi_wready = !w_full_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // write takes effect once both halves are held and no response is pending
  always_comb
  begin
    do_wr = aw_full_r && w_full_r && !bvalid_r;
    wr_lane0 = do_wr && ws_r[0];
    wr_mapped = hit(aw_r, ADDR_COUNT) || hit(aw_r, ADDR_CTRL) || hit(aw_r, ADDR_PERIOD)
      || hit(aw_r, ADDR_FLAGS) || hit(aw_r, ADDR_ENABLES);
    wr_count = wr_lane0 && hit(aw_r, ADDR_COUNT);
    wr_ctrl = wr_lane0 && hit(aw_r, ADDR_CTRL);
    wr_period = wr_lane0 && hit(aw_r, ADDR_PERIOD);
    wr_flags = wr_lane0 && hit(aw_r, ADDR_FLAGS);
    wr_en = wr_lane0 && hit(aw_r, ADDR_ENABLES);
  end

  // axi write channel next state
  always_comb
  begin
    aw_nxt = aw_r;
    aw_full_nxt = aw_full_r;
    w_nxt = w_r;
    ws_nxt = ws_r;
    w_full_nxt = w_full_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    // address and data are taken in either order
    if (s_axi_awvalid && !aw_full_r)
    begin
      aw_nxt = s_axi_awaddr;
      aw_full_nxt = 1'b1;
    end
    if (s_axi_wvalid && !w_full_r)
    begin
      w_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
      w_full_nxt = 1'b1;
    end
    // commit: answer in the next cycle, unmapped gets slverr
    if (do_wr)
    begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
  end

  // read mux, reserved and upper bits read zero
  always_comb
  begin
    rd_word = BYTE_ZERO;
    rd_mapped = 1'b1;
    if (hit(s_axi_araddr, ADDR_COUNT))
      rd_word = count_r;
    else if (hit(s_axi_araddr, ADDR_CTRL))
      rd_word = {1'b0, ctrl_r};
    else if (hit(s_axi_araddr, ADDR_PERIOD))
      rd_word = period_r;
    else if (hit(s_axi_araddr, ADDR_FLAGS))
    begin
      rd_word = other_flags_r;
      rd_word[MATCH_BIT] = match_flag_r;
    end
    else if (hit(s_axi_araddr, ADDR_ENABLES))
    begin
      rd_word = other_en_r;
      rd_word[MATCH_BIT] = match_en_r;
    end
    else
      rd_mapped = 1'b0;
  end

  // axi read channel next state
  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt = {24'h000000, rd_word};
      rresp_nxt = rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
  end

  // timer next state
  always_comb
  begin
    count_nxt = count_r;
    period_nxt = period_r;
    ctrl_nxt = ctrl_r;
    insn_nxt = insn_r;
    pre_nxt = pre_r;
    post_nxt = post_r;
    match_flag_nxt = match_flag_r;
    match_en_nxt = match_en_r;
    other_flags_nxt = other_flags_r;
    other_en_nxt = other_en_r;
    match_now = 1'b0;
    insn_tick = 1'b0;
    pre_tick = 1'b0;
    // instruction clock and prescaler only move while running
    if (ctrl_r.timer_run)
    begin
      insn_nxt = insn_r + 2'h1;
      insn_tick = (insn_r == INSN_LAST);
      if (insn_tick)
      begin
        if (pre_r >= pre_last(ctrl_r.pre_divide_select))
        begin
          pre_nxt = 4'h0;
          pre_tick = 1'b1;
        end
        else
          pre_nxt = pre_r + 4'h1;
      end
    end
    // count up; the increment that finds count equal to period wraps to zero and signals the match
    if (pre_tick)
    begin
      if (count_r == period_r)
      begin
        count_nxt = COUNT_RST;
        match_now = 1'b1;
        if (post_r >= ctrl_r.post_divide_select)
        begin
          post_nxt = 4'h0;
          match_flag_nxt = 1'b1;
        end
        else
          post_nxt = post_r + 4'h1;
      end
      else
        count_nxt = count_r + 8'h01;
    end
    // software writes; a write of zero clears, hardware set still wins below
    if (wr_flags)
    begin
      other_flags_nxt = w_r[7:0];
      if (!w_r[MATCH_BIT] && !match_flag_nxt)
        match_flag_nxt = 1'b0;
      else if (!w_r[MATCH_BIT] && !(pre_tick && match_now && post_r >= ctrl_r.post_divide_select))
        match_flag_nxt = 1'b0;
      else if (w_r[MATCH_BIT])
        match_flag_nxt = 1'b1;
    end
    if (wr_en)
    begin
      other_en_nxt = w_r[7:0];
      match_en_nxt = w_r[MATCH_BIT];
    end
    if (wr_period)
      period_nxt = w_r[7:0];
    if (wr_count)
      count_nxt = w_r[7:0];
    if (wr_ctrl)
      ctrl_nxt = w_r[6:0];
    // either write restarts both scalers
    if (wr_count || wr_ctrl)
    begin
      pre_nxt = 4'h0;
      post_nxt = 4'h0;
      insn_nxt = 2'h0;
    end
    match_pulse_nxt = match_now;
  end

  // all registers, synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_r <= COUNT_RST;
      period_r <= PERIOD_RST;
      ctrl_r <= CTRL_RST;
      insn_r <= 2'h0;
      pre_r <= 4'h0;
      post_r <= 4'h0;
      match_flag_r <= 1'b0;
      match_en_r <= 1'b0;
      other_flags_r <= BYTE_ZERO;
      other_en_r <= BYTE_ZERO;
      match_pulse_r <= 1'b0;
      aw_r <= 12'h000;
      aw_full_r <= 1'b0;
      w_r <= 32'h00000000;
      ws_r <= 4'h0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end
    else
    begin
      count_r <= count_nxt;
      period_r <= period_nxt;
      ctrl_r <= ctrl_nxt;
      insn_r <= insn_nxt;
      pre_r <= pre_nxt;
      post_r <= post_nxt;
      match_flag_r <= match_flag_nxt;
      match_en_r <= match_en_nxt;
      other_flags_r <= other_flags_nxt;
      other_en_r <= other_en_nxt;
      match_pulse_r <= match_pulse_nxt;
      aw_r <= aw_nxt;
      aw_full_r <= aw_full_nxt;
      w_r <= w_nxt;
      ws_r <= ws_nxt;
      w_full_r <= w_full_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // outputs from flops
  assign irq = match_flag_r && match_en_r;
  assign sync_serial_port_tick = match_pulse_r;
  assign capture_compare_pwm_unit_base = '{count: count_r, match: match_pulse_r};
endmodule

// File: tb/timer_monitor.sv
// checker for the period timer ports
`timescale 1ns/10ps
module timer_monitor
  import period_timer_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // timer outputs
  input wire logic irq,
  input wire logic sync_serial_port_tick,
  input wire pwm_base_t capture_compare_pwm_unit_base
);
  // short alias for the exported count
  wire logic [7:0] cnt = capture_compare_pwm_unit_base.count;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // serial tick and pwm match are the same pulse
  property p_tick_base;
    sync_serial_port_tick == capture_compare_pwm_unit_base.match;
  endproperty
  a_tick_base: assert property (p_tick_base) else $error("tick and pwm match differ");
  // matches are at least one instruction tick apart
  property p_tick_gap;
    sync_serial_port_tick |=> !sync_serial_port_tick [*3];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("match pulses too close");
  // outside writes the count only steps by one or wraps to zero
  property p_count_step;
    $changed(cnt) && !s_axi_bvalid && !$past(s_axi_bvalid) |-> cnt == $past(cnt) + 8'h01 || cnt == 8'h00;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count jumped");
  // interrupt rises only after a match or a register write
  property p_irq_src;
    $rose(irq) |-> s_axi_bvalid || $past(s_axi_bvalid) || sync_serial_port_tick
      || $past(sync_serial_port_tick) || $past(sync_serial_port_tick, 2) || $past(sync_serial_port_tick, 3);
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("interrupt rose without cause");
  // sticky: only a write can drop the interrupt; the write lands at the edge that raises bvalid
  property p_irq_hold;
    irq |=> irq || s_axi_bvalid;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped by itself");
  // write response stands until taken
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  // read data stands until taken
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  // read answer one cycle after the address is taken
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
endmodule
bind period_timer_with_scalers timer_monitor i_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .irq(irq), .sync_serial_port_tick(sync_serial_port_tick),
  .capture_compare_pwm_unit_base(capture_compare_pwm_unit_base));

// File: tb/tb.sv
// self-checking bench for the period timer
`timescale 1ns/10ps
module tb;
  import period_timer_pkg::*;
  localparam logic [11:0] A_FLG = {2'h0, ADDR_FLAGS};
  localparam logic [11:0] A_CNT = {2'h0, ADDR_COUNT};
  localparam logic [11:0] A_CTL = {2'h0, ADDR_CTRL};
  localparam logic [11:0] A_ENA = {2'h0, ADDR_ENABLES};
  localparam logic [11:0] A_PER = {2'h0, ADDR_PERIOD};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, sync_serial_port_tick;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [31:0] rnd = 32'hF1C9;
  pwm_base_t capture_compare_pwm_unit_base;
  int errors = 0, n_compared = 0, n, k, c, i;
  // 125 MHz clock
  always #4 aclk = ~aclk;
  period_timer_with_scalers i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq), .sync_serial_port_tick(sync_serial_port_tick),
    .capture_compare_pwm_unit_base(capture_compare_pwm_unit_base));
  // random source, fixed start
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected clocks between matches
  function automatic logic [31:0] gap(input logic [1:0] pc, input logic [1:0] p);
    return 32'h4 * (pc == 2'h0 ? 32'h1 : pc == 2'h1 ? 32'h4 : 32'h10) * ({30'h0, p} + 32'h1);
  endfunction
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // a bound ran out
  task automatic hang;
    errors++;
    tally_and_finish();
  endtask
  // one write, halves released as taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    int j;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {rnd[31:8], d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (j = 0; j < 64; j++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        chk({30'h0, s_axi_bresp}, {30'h0, r});
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (j == 64)
      hang();
  endtask
  // one read, data compared in full
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    int j;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (j = 0; j < 64; j++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        chk(s_axi_rdata, {24'h0, d});
        chk({30'h0, s_axi_rresp}, {30'h0, r});
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (j == 64)
      hang();
  endtask
  // clocks from one match pulse to the next
  task automatic meas;
    @(negedge aclk);
    for (i = 0; i < 3000 && sync_serial_port_tick !== 1'b1; i++)
      @(negedge aclk);
    @(negedge aclk);
    for (n = 1; n < 3000 && sync_serial_port_tick !== 1'b1; n++)
      @(negedge aclk);
    if (n == 3000 || i == 3000)
      hang();
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values
    rd(A_FLG, BYTE_ZERO, RESP_OKAY);
    rd(A_CNT, COUNT_RST, RESP_OKAY);
    rd(A_CTL, 8'h00, RESP_OKAY);
    rd(A_ENA, BYTE_ZERO, RESP_OKAY);
    rd(A_PER, PERIOD_RST, RESP_OKAY);
    // unmapped place refuses
    wr(12'hFFC, 8'hA5, RESP_SLVERR);
    rd(12'hFFC, 8'h00, RESP_SLVERR);
    // stopped timer holds its count across a control write
    rnd = lfsr(rnd);
    wr(A_CNT, rnd[7:0], RESP_OKAY);
    wr(A_PER, rnd[15:8], RESP_OKAY);
    wr(A_CTL, 8'h1A, RESP_OKAY);
    repeat (40) @(posedge aclk);
    rd(A_CNT, rnd[7:0], RESP_OKAY);
    rd(A_PER, rnd[15:8], RESP_OKAY);
    rd(A_CTL, 8'h1A, RESP_OKAY);
    chk({24'h0, capture_compare_pwm_unit_base.count}, {24'h0, rnd[7:0]});
    // every prescale code with a short random period
    for (c = 0; c < 4; c++)
    begin
      rnd = lfsr(rnd);
      wr(A_PER, {6'h0, rnd[1:0]}, RESP_OKAY);
      wr(A_CNT, 8'h00, RESP_OKAY);
      wr(A_CTL, {5'h0, 1'b1, c[1:0]}, RESP_OKAY);
      meas();
      chk(n, gap(c[1:0], rnd[1:0]));
    end
    // postscale 1, 16 and random, counted up to the interrupt
    wr(A_ENA, 8'h02, RESP_OKAY);
    for (k = 0; k < 3; k++)
    begin
      rnd = lfsr(rnd);
      c = (k == 0) ? 0 : (k == 1) ? 15 : int'(rnd[3:0]);
      wr(A_CTL, 8'h00, RESP_OKAY);
      wr(A_FLG, 8'h00, RESP_OKAY);
      wr(A_PER, 8'h00, RESP_OKAY);
      wr(A_CNT, 8'h00, RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      wr(A_CTL, {1'b0, c[3:0], 1'b1, 2'h0}, RESP_OKAY);
      n = 0;
      for (i = 0; i < 2000 && irq !== 1'b1; i++)
      begin
        @(negedge aclk);
        if (sync_serial_port_tick === 1'b1)
          n++;
      end
      if (i == 2000)
        hang();
      chk(n, c + 1);
    end
    // masked line drops, flag stays until written to zero
    wr(A_CTL, 8'h00, RESP_OKAY);
    wr(A_ENA, 8'h00, RESP_OKAY);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(A_FLG, 8'h02, RESP_OKAY);
    wr(A_FLG, 8'h00, RESP_OKAY);
    rd(A_FLG, 8'h00, RESP_OKAY);
    // a write without the low byte lane is answered but changes nothing
    s_axi_wstrb <= 4'hE;
    wr(A_PER, 8'h55, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(A_PER, 8'h00, RESP_OKAY);
    tally_and_finish();
  end
endmodule
